// file: design/async_serial_adapter.sv
`timescale 1ns/1ps
module async_serial_adapter #(
	parameter int DATA_W = 8
) (
	// System
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	// Processor bus
	input  wire logic       e,
	input  wire logic       rw,
	input  wire logic       pair_select,
	input  wire logic       select_high_a,
	input  wire logic       select_high_b,
	input  wire logic       select_low_c_b,
	input  wire logic [7:0] d_in,
	output logic      [7:0] d_out,
	output logic            d_oe_b,
	// Interrupt, open drain
	output logic            irq_out,
	output logic            irq_oe_b,
	// Serial side
	input  wire logic       tx_clk,
	input  wire logic       rx_clk,
	input  wire logic       rx_data_in,
	output logic            tx_data_out,
	// Modem lines
	input  wire logic       cts_b,
	input  wire logic       carrier_detect_in_b,
	output logic            rts_b
);
	// The byte bus cannot be widened
	if (DATA_W != 8) begin : g_width_check
		$error("DATA_W must be 8");
	end

	serial_if sp ();

	// Pin vector through two flip-flops
	logic [18:0] pin_w, sync1_r, sync2_r;
	logic        e_d_r, txc_d_r, rxc_d_r, dcd_d_r;
	logic        e_s, rw_s, rs_s, sel_s, txc_s, rxc_s, rxd_s, cts_s, dcd_s;
	logic [7:0]  din_s;

	// Bus latch taken while enable is high
	logic [7:0]  hd_r, hd_nxt;
	logic        hrs_r, hrs_nxt, hrw_r, hrw_nxt, hsel_r, hsel_nxt;
	logic        e_fall, wr_ctl, wr_tdr, rd_sts, rd_rdr;

	// Register state
	logic [7:0]  ctrl_r, ctrl_nxt;
	logic [7:0]  tdr_r, tdr_nxt;
	logic [7:0]  rdr_r, rdr_nxt;
	logic        tx_holding_empty_r, tx_holding_empty_nxt;
	logic        rx_holding_full_r, rx_holding_full_nxt;
	logic        fe_r, fe_nxt;
	logic        pe_r, pe_nxt;
	logic        overrun_flag_r, overrun_flag_nxt;
	logic        dcd_lat_r, dcd_lat_nxt;
	logic        seen_r, seen_nxt;
	logic        por_r, por_nxt;
	logic        irq_r, irq_nxt;
	logic        rts_b_r, rts_b_nxt;
	logic        txd_r, txd_nxt;
	logic [7:0]  rd_r, rd_nxt;

	// Derived terms
	logic        mrst, tx_holding_empty_st, rx_holding_full_st, tx_irq, rx_irq, dcd_rise;
	logic [7:0]  status;

	assign pin_w = {d_in, e, rw, pair_select, select_high_a & select_high_b & ~select_low_c_b,
		tx_clk, rx_clk, rx_data_in, cts_b, carrier_detect_in_b, 2'h0};

	// Two-stage synchroniser; only stage two is read by logic
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			sync1_r <= 19'h00000;
			sync2_r <= 19'h00000;
		end else begin
			sync1_r <= pin_w;
			sync2_r <= sync1_r;
		end
	end

	assign din_s = sync2_r[18:11];
	assign e_s   = sync2_r[10];
	assign rw_s  = sync2_r[9];
	assign rs_s  = sync2_r[8];
	assign sel_s = sync2_r[7];
	assign txc_s = sync2_r[6];
	assign rxc_s = sync2_r[5];
	assign rxd_s = sync2_r[4];
	assign cts_s = sync2_r[3];
	assign dcd_s = sync2_r[2];

	// Edge history of the synchronised clocks and lines
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			e_d_r   <= 1'h0;
			txc_d_r <= 1'h0;
			rxc_d_r <= 1'h0;
			dcd_d_r <= 1'h0;
		end else begin
			e_d_r   <= e_s;
			txc_d_r <= txc_s;
			rxc_d_r <= rxc_s;
			dcd_d_r <= dcd_s;
		end
	end

	// Address and data are caught while enable is high, since they may
	// already have moved by the time the falling edge is seen
	always_comb begin
		hd_nxt   = e_s ? din_s : hd_r;
		hrs_nxt  = e_s ? rs_s : hrs_r;
		hrw_nxt  = e_s ? rw_s : hrw_r;
		hsel_nxt = e_s ? sel_s : hsel_r;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			hd_r   <= 8'h00;
			hrs_r  <= 1'h0;
			hrw_r  <= 1'h0;
			hsel_r <= 1'h0;
		end else begin
			hd_r   <= hd_nxt;
			hrs_r  <= hrs_nxt;
			hrw_r  <= hrw_nxt;
			hsel_r <= hsel_nxt;
		end
	end

	// Access strobes on the falling edge of enable
	assign e_fall = e_d_r & ~e_s;
	assign wr_ctl = e_fall & hsel_r & ~hrw_r & (hrs_r != serial_adapter_pkg::PAIR_DATA);
	assign wr_tdr = e_fall & hsel_r & ~hrw_r & (hrs_r == serial_adapter_pkg::PAIR_DATA);
	assign rd_sts = e_fall & hsel_r & hrw_r & (hrs_r != serial_adapter_pkg::PAIR_DATA);
	assign rd_rdr = e_fall & hsel_r & hrw_r & (hrs_r == serial_adapter_pkg::PAIR_DATA);

	// Master reset holds while the divide field reads 11, or until the first one
	assign mrst = por_r | (ctrl_r[serial_adapter_pkg::CTL_DIV +: 2] == serial_adapter_pkg::DIV_MRST);

	assign tx_holding_empty_st  = tx_holding_empty_r & ~cts_s & ~mrst;
	assign rx_holding_full_st  = rx_holding_full_r & ~dcd_s;
	assign dcd_rise = dcd_s & ~dcd_d_r;
	assign tx_irq   = (ctrl_r[serial_adapter_pkg::CTL_TXC +: 2] == serial_adapter_pkg::TXC_IRQ_ON) & tx_holding_empty_st;
	assign rx_irq   = ctrl_r[serial_adapter_pkg::CTL_RIE] & (rx_holding_full_st | overrun_flag_r | dcd_lat_r);

	// Status byte in its fixed bit order; bit 7 takes the next interrupt value so that
	// the registered read byte lines up with the registered pin
	always_comb begin
		status = 8'h00;
		status[serial_adapter_pkg::ST_RX_HOLDING_FULL] = rx_holding_full_st;
		status[serial_adapter_pkg::ST_TX_HOLDING_EMPTY] = tx_holding_empty_st;
		status[serial_adapter_pkg::ST_DCD]  = dcd_lat_r | dcd_s;
		status[serial_adapter_pkg::ST_CTS]  = cts_s;
		status[serial_adapter_pkg::ST_FE]   = fe_r;
		status[serial_adapter_pkg::ST_OVERRUN_FLAG] = overrun_flag_r;
		status[serial_adapter_pkg::ST_PE]   = pe_r;
		status[serial_adapter_pkg::ST_IRQ]  = irq_nxt;
	end

	// Serial engines: fields decode immediately, unbuffered
	assign sp.div     = ctrl_r[serial_adapter_pkg::CTL_DIV +: 2];
	assign sp.word    = ctrl_r[serial_adapter_pkg::CTL_WORD +: 3];
	assign sp.tx_req  = ~tx_holding_empty_r;
	assign sp.tx_data = tdr_r;

	serial_tx u_tx (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.init    (mrst),
		.tick    (txc_d_r & ~txc_s),
		.sp      (sp)
	);

	serial_rx u_rx (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.init    (mrst | dcd_s),
		.tick    (rxc_s & ~rxc_d_r),
		.rxd     (rxd_s),
		.sp      (sp)
	);

	// Register next values; read clears come before hardware sets, a data write after the take, master reset last
	always_comb begin
		ctrl_nxt    = wr_ctl ? hd_r : ctrl_r;
		tdr_nxt     = wr_tdr ? hd_r : tdr_r;
		por_nxt     = por_r & ~(wr_ctl && hd_r[serial_adapter_pkg::CTL_DIV +: 2] == serial_adapter_pkg::DIV_MRST);
		rdr_nxt     = rdr_r;
		rx_holding_full_nxt    = rx_holding_full_r;
		fe_nxt      = fe_r;
		pe_nxt      = pe_r;
		overrun_flag_nxt    = overrun_flag_r;
		dcd_lat_nxt = dcd_lat_r;
		seen_nxt    = seen_r;
		// A write overwrites any pending take, so the new byte stays queued
		tx_holding_empty_nxt    = tx_holding_empty_r;
		if (sp.tx_take)
			tx_holding_empty_nxt = 1'h1;
		if (wr_tdr)
			tx_holding_empty_nxt = 1'h0;
		// Status read arms the error clear
		if (rd_sts && (overrun_flag_r || dcd_lat_r))
			seen_nxt = 1'h1;
		if (rd_rdr) begin
			rx_holding_full_nxt = overrun_flag_r & ~seen_r;
			if (seen_r) begin
				overrun_flag_nxt = 1'h0;
				dcd_lat_nxt = 1'h0;
				seen_nxt = 1'h0;
			end
		end
		if (sp.rx_done) begin
			if (rx_holding_full_r) begin
				overrun_flag_nxt = 1'h1;
			end else begin
				rdr_nxt = sp.rx_data;
				fe_nxt = sp.rx_fe;
				pe_nxt = sp.rx_pe;
				rx_holding_full_nxt = 1'h1;
			end
		end
		if (dcd_rise)
			dcd_lat_nxt = 1'h1;
		if (mrst) begin
			tx_holding_empty_nxt = 1'h1;
			rx_holding_full_nxt = 1'h0;
			fe_nxt = 1'h0;
			pe_nxt = 1'h0;
			overrun_flag_nxt = 1'h0;
			dcd_lat_nxt = 1'h0;
			seen_nxt = 1'h0;
		end
	end

	// Output next values
	always_comb begin
		irq_nxt   = ~mrst & (tx_irq | rx_irq);
		rts_b_nxt = por_r | (ctrl_r[serial_adapter_pkg::CTL_TXC +: 2] == 2'h2);
		txd_nxt   = (ctrl_r[serial_adapter_pkg::CTL_TXC +: 2] == serial_adapter_pkg::TXC_BREAK) ? 1'h0 : sp.txd;
		rd_nxt    = (rs_s == serial_adapter_pkg::PAIR_DATA) ? rdr_r : status;
	end

	// Registers only
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ctrl_r    <= serial_adapter_pkg::CTL_RST;
			tdr_r     <= serial_adapter_pkg::BYTE_ZERO;
			rdr_r     <= serial_adapter_pkg::BYTE_ZERO;
			tx_holding_empty_r    <= 1'h1;
			rx_holding_full_r    <= 1'h0;
			fe_r      <= 1'h0;
			pe_r      <= 1'h0;
			overrun_flag_r    <= 1'h0;
			dcd_lat_r <= 1'h0;
			seen_r    <= 1'h0;
			por_r     <= 1'h1;
			irq_r     <= 1'h0;
			rts_b_r   <= 1'h1;
			txd_r     <= 1'h1;
			rd_r      <= serial_adapter_pkg::BYTE_ZERO;
		end else begin
			ctrl_r    <= ctrl_nxt;
			tdr_r     <= tdr_nxt;
			rdr_r     <= rdr_nxt;
			tx_holding_empty_r    <= tx_holding_empty_nxt;
			rx_holding_full_r    <= rx_holding_full_nxt;
			fe_r      <= fe_nxt;
			pe_r      <= pe_nxt;
			overrun_flag_r    <= overrun_flag_nxt;
			dcd_lat_r <= dcd_lat_nxt;
			seen_r    <= seen_nxt;
			por_r     <= por_nxt;
			irq_r     <= irq_nxt;
			rts_b_r   <= rts_b_nxt;
			txd_r     <= txd_nxt;
			rd_r      <= rd_nxt;
		end
	end

	// Pins; bus drivers on only while a selected read holds enable high
	assign d_out       = rd_r;
	assign d_oe_b      = ~(e_s & sel_s & rw_s);
	assign irq_out     = 1'h0;
	assign irq_oe_b    = ~irq_r;
	assign rts_b       = rts_b_r;
	assign tx_data_out = txd_r;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	bus_off_a: assert property (!(e_s && sel_s && rw_s) |-> d_oe_b)
		else $error("data bus driven outside a read");
	irq_pin_a: assert property (irq_oe_b == !d_out[7] || rs_s || $past(rs_s))
		else $error("interrupt pin and status bit disagree");
	tx_irq_a: assert property (tx_irq && !mrst |=> !irq_oe_b)
		else $error("transmit interrupt not raised");
	cts_mask_a: assert property (cts_s |-> !status[serial_adapter_pkg::ST_TX_HOLDING_EMPTY])
		else $error("empty flag visible with clear-to-send high");
	tdr_write_a: assert property (wr_tdr && !mrst |=> !tx_holding_empty_r && !tx_irq)
		else $error("write left transmit register empty");
	rts_level_a: assert property (!por_r && !$past(por_r) && $stable(ctrl_r) |=>
		rts_b == ($past(ctrl_r[6]) && !$past(ctrl_r[5])))
		else $error("request-to-send level wrong");
	rx_load_a: assert property (sp.rx_done && !rx_holding_full_r && !mrst |=> rx_holding_full_r && rdr_r == $past(sp.rx_data))
		else $error("received character not stored");
	rx_block_a: assert property (sp.rx_done && rx_holding_full_r && !mrst |=> $stable(rdr_r) && $stable(fe_r))
		else $error("full holding register overwritten");
	rd_keep_a: assert property (rd_rdr && !sp.rx_done && !overrun_flag_r |=> !rx_holding_full_r && $stable(rdr_r))
		else $error("data read did not clear full flag");
	mrst_a: assert property (mrst |=> !rx_holding_full_r && !overrun_flag_r && !fe_r && !irq_r)
		else $error("master reset left status set");
	overrun_flag_hold_a: assert property (overrun_flag_r && rd_rdr && !seen_r && !mrst |=> overrun_flag_r)
		else $error("overrun cleared without status read");
	break_a: assert property (ctrl_r[6:5] == serial_adapter_pkg::TXC_BREAK |=> !tx_data_out)
		else $error("break level not sent");
endmodule : async_serial_adapter

// file: design/serial_adapter_pkg.sv
package serial_adapter_pkg;
	// Divide-select codes
	localparam logic [1:0] DIV_1     = 2'h0;
	localparam logic [1:0] DIV_16    = 2'h1;
	localparam logic [1:0] DIV_64    = 2'h2;
	localparam logic [1:0] DIV_MRST  = 2'h3;
	// Transmit-control codes
	localparam logic [1:0] TXC_IRQ_ON = 2'h1;
	localparam logic [1:0] TXC_BREAK  = 2'h3;
	// Control register field positions
	localparam int CTL_DIV  = 0;
	localparam int CTL_WORD = 2;
	localparam int CTL_TXC  = 5;
	localparam int CTL_RIE  = 7;
	// Status register bit positions
	localparam int ST_RX_HOLDING_FULL = 0;
	localparam int ST_TX_HOLDING_EMPTY = 1;
	localparam int ST_DCD  = 2;
	localparam int ST_CTS  = 3;
	localparam int ST_FE   = 4;
	localparam int ST_OVERRUN_FLAG = 5;
	localparam int ST_PE   = 6;
	localparam int ST_IRQ  = 7;
	// Pair select level for the data registers
	localparam logic PAIR_DATA = 1'h1;
	// Reset values
	localparam logic [7:0] CTL_RST   = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// Serial engine states
	typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_SHIFT = 2'h1} tx_state_t;
	typedef enum logic [1:0] {RX_HUNT = 2'h0, RX_BITS = 2'h1} rx_state_t;
	// Clock ticks per bit for a divide code
	function automatic logic [6:0] div_ticks(input logic [1:0] d);
		div_ticks = (d == DIV_16) ? 7'h10 : (d == DIV_64) ? 7'h40 : 7'h01;
	endfunction : div_ticks
	// Word-select decode
	function automatic logic word_len8(input logic [2:0] w);
		word_len8 = w[2];
	endfunction : word_len8
	function automatic logic word_par(input logic [2:0] w);
		word_par = ~w[2] | w[1];
	endfunction : word_par
	function automatic logic word_stop2(input logic [2:0] w);
		word_stop2 = ~w[1] & ~(w[2] & w[0]);
	endfunction : word_stop2
endpackage : serial_adapter_pkg

// file: design/serial_if.sv
`timescale 1ns/1ps
interface serial_if;
	logic [1:0] div;
	logic [2:0] word;
	logic       tx_req;
	logic [7:0] tx_data;
	logic       tx_take;
	logic       txd;
	logic       rx_done;
	logic [7:0] rx_data;
	logic       rx_fe;
	logic       rx_pe;
	modport ctl (output div, word, tx_req, tx_data, input tx_take, txd, rx_done, rx_data, rx_fe, rx_pe);
	modport tx  (input div, word, tx_req, tx_data, output tx_take, txd);
	modport rx  (input div, word, output rx_done, rx_data, rx_fe, rx_pe);
endinterface : serial_if

// file: design/serial_tx.sv
`timescale 1ns/1ps
module serial_tx (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic init,
	input wire logic tick,
	serial_if.tx     sp
);
	serial_adapter_pkg::tx_state_t state_r, state_nxt;
	logic [5:0]  phase_r, phase_nxt;
	logic [11:0] sh_r, sh_nxt;
	logic [3:0]  left_r, left_nxt;
	logic        txd_r, txd_nxt;
	logic        bit_en, len8, pen, par;
	logic [7:0]  dbits;
	logic [11:0] frame;
	logic [3:0]  nbits;

	// Phase runs free so an idle start waits at most one bit time
	always_comb begin
		len8   = serial_adapter_pkg::word_len8(sp.word);
		pen    = serial_adapter_pkg::word_par(sp.word);
		dbits  = len8 ? sp.tx_data : {1'h0, sp.tx_data[6:0]};
		par    = ^dbits ^ sp.word[0];
		frame  = len8 ? {2'h3, pen ? par : 1'h1, sp.tx_data, 1'h0} : {3'h7, par, sp.tx_data[6:0], 1'h0};
		nbits  = (len8 ? 4'hA : 4'h9) + {3'h0, pen} + {3'h0, serial_adapter_pkg::word_stop2(sp.word)};
		bit_en = tick && ({1'h0, phase_r} == serial_adapter_pkg::div_ticks(sp.div) - 7'h01);
		phase_nxt = bit_en ? 6'h00 : tick ? phase_r + 6'h01 : phase_r;
		state_nxt = state_r;
		sh_nxt = sh_r;
		left_nxt = left_r;
		sp.tx_take = 1'h0;
		if (bit_en && state_r == serial_adapter_pkg::TX_SHIFT) begin
			sh_nxt = {1'h1, sh_r[11:1]};
			left_nxt = left_r - 4'h1;
			if (left_r == 4'h1)
				state_nxt = serial_adapter_pkg::TX_IDLE;
		end
		// Back-to-back characters load on the boundary that ends the last
		if (bit_en && state_nxt == serial_adapter_pkg::TX_IDLE && sp.tx_req) begin
			sp.tx_take = 1'h1;
			sh_nxt = frame;
			left_nxt = nbits;
			state_nxt = serial_adapter_pkg::TX_SHIFT;
		end
		if (init) begin
			state_nxt = serial_adapter_pkg::TX_IDLE;
			phase_nxt = 6'h00;
			sp.tx_take = 1'h0;
		end
		txd_nxt = (state_nxt == serial_adapter_pkg::TX_SHIFT) ? sh_nxt[0] : 1'h1;
	end

	// Bits change only on a transmit clock falling edge tick, or at once when init forces the line idle
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state_r <= serial_adapter_pkg::TX_IDLE;
			phase_r <= 6'h00;
			sh_r    <= 12'hFFF;
			left_r  <= 4'h0;
			txd_r   <= 1'h1;
		end else begin
			state_r <= state_nxt;
			phase_r <= phase_nxt;
			sh_r    <= sh_nxt;
			left_r  <= left_nxt;
			txd_r   <= txd_nxt;
		end
	end

	assign sp.txd = txd_r;
endmodule : serial_tx

// file: design/serial_rx.sv
`timescale 1ns/1ps
module serial_rx (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic init,
	input wire logic tick,
	input wire logic rxd,
	serial_if.rx     sp
);
	serial_adapter_pkg::rx_state_t state_r, state_nxt;
	logic [6:0] cnt_r, cnt_nxt;
	logic [3:0] got_r, got_nxt;
	logic [9:0] sr_r, sr_nxt;
	logic       done_r, done_nxt, fe_r, fe_nxt, pe_r, pe_nxt;
	logic [7:0] data_r, data_nxt;
	logic [6:0] ticks, half;
	logic [3:0] need;
	logic [9:0] al;
	logic       len8;

	// Start needs half a bit of low samples; a high sample restarts the hunt
	always_comb begin
		len8  = serial_adapter_pkg::word_len8(sp.word);
		ticks = serial_adapter_pkg::div_ticks(sp.div);
		half  = (ticks == 7'h01) ? 7'h01 : {1'h0, ticks[6:1]};
		need  = (len8 ? 4'h9 : 4'h8) + {3'h0, serial_adapter_pkg::word_par(sp.word)};
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		got_nxt = got_r;
		sr_nxt = sr_r;
		done_nxt = 1'h0;
		data_nxt = data_r;
		fe_nxt = fe_r;
		pe_nxt = pe_r;
		al = sr_r;
		if (tick && state_r == serial_adapter_pkg::RX_HUNT) begin
			cnt_nxt = rxd ? 7'h00 : cnt_r + 7'h01;
			if (!rxd && cnt_r + 7'h01 == half) begin
				state_nxt = serial_adapter_pkg::RX_BITS;
				cnt_nxt = 7'h00;
				got_nxt = 4'h0;
			end
		end else if (tick) begin
			cnt_nxt = cnt_r + 7'h01;
			if (cnt_r + 7'h01 == ticks) begin
				cnt_nxt = 7'h00;
				sr_nxt = {rxd, sr_r[9:1]};
				got_nxt = got_r + 4'h1;
				if (got_r + 4'h1 == need) begin
					al = sr_nxt >> (4'hA - need);
					done_nxt = 1'h1;
					state_nxt = serial_adapter_pkg::RX_HUNT;
					data_nxt = len8 ? al[7:0] : {1'h0, al[6:0]};
					fe_nxt = ~al[need - 4'h1];
					pe_nxt = serial_adapter_pkg::word_par(sp.word) &
						(^data_nxt ^ (len8 ? al[8] : al[7]) ^ sp.word[0]);
				end
			end
		end
		if (init) begin
			state_nxt = serial_adapter_pkg::RX_HUNT;
			cnt_nxt = 7'h00;
			done_nxt = 1'h0;
		end
	end

	// Character and flags are held until the next character completes
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state_r <= serial_adapter_pkg::RX_HUNT;
			cnt_r   <= 7'h00;
			got_r   <= 4'h0;
			sr_r    <= 10'h000;
			done_r  <= 1'h0;
			data_r  <= 8'h00;
			fe_r    <= 1'h0;
			pe_r    <= 1'h0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			got_r   <= got_nxt;
			sr_r    <= sr_nxt;
			done_r  <= done_nxt;
			data_r  <= data_nxt;
			fe_r    <= fe_nxt;
			pe_r    <= pe_nxt;
		end
	end

	assign sp.rx_done = done_r;
	assign sp.rx_data = data_r;
	assign sp.rx_fe   = fe_r;
	assign sp.rx_pe   = pe_r;
endmodule : serial_rx

// file: verification/serial_peer.sv
`timescale 1ns/1ps
module serial_peer (
	// Serial clocks and data
	output logic      tx_clk,
	output logic      rx_clk,
	output logic      rx_data_in,
	input  wire logic tx_data_out,
	// Modem lines
	output logic      cts_b,
	output logic      carrier_detect_in_b
);
	logic [7:0] got;
	logic [7:0] got_q[$];

	// Both clocks run free, the receiver needs the receive clock alive
	initial begin
		tx_clk = 1'b1;
		cts_b = 1'b0;
		carrier_detect_in_b = 1'b0;
		rx_data_in = 1'b1;
		forever #100 tx_clk = ~tx_clk;
	end
	initial begin
		rx_clk = 1'b1;
		forever #115 rx_clk = ~rx_clk;
	end

	// Frame sent LSB first, per receive clocks per bit, changed on falls
	task automatic send_frame(input logic [11:0] f, input int n, input int per);
		for (int i = 0; i < n; i++) begin
			@(negedge rx_clk);
			rx_data_in = f[i];
			repeat (per - 1) @(negedge rx_clk);
		end
	endtask : send_frame

	// Frame of 8 data bits, one stop, 16 receive clocks per bit
	task automatic send_byte(input logic [7:0] b);
		send_frame({3'h7, b, 1'b0}, 10, 16);
	endtask : send_byte

	// Sample the transmit line at mid-bit on rising edges, after the start edge
	initial begin
		forever begin
			@(posedge tx_clk);
			if (tx_data_out === 1'b0) begin
				repeat (8) @(posedge tx_clk);
				for (int i = 0; i < 8; i++) begin
					repeat (16) @(posedge tx_clk);
					got[i] = tx_data_out;
				end
				repeat (16) @(posedge tx_clk);
				got_q.push_back(got);
			end
		end
	end
endmodule : serial_peer

// file: verification/async_serial_adapter_tb.sv
`timescale 1ns/1ps
module async_serial_adapter_tb;
	logic       clk_sys;
	logic       rst_b;
	logic       e;
	logic       rw;
	logic       pair_select;
	logic       select_high_a;
	logic       select_high_b;
	logic       select_low_c_b;
	logic [7:0] d_in;
	logic [7:0] d_out;
	logic       d_oe_b;
	logic       irq_out;
	logic       irq_oe_b;
	logic       tx_clk;
	logic       rx_clk;
	logic       rx_data_in;
	logic       tx_data_out;
	logic       cts_b;
	logic       carrier_detect_in_b;
	logic       rts_b;
	logic [7:0] rd;
	int         bad_count;
	int         comparisons;
	int         cyc;

	async_serial_adapter #(.DATA_W(8)) u_async_serial_adapter (
		.clk_sys(clk_sys), .rst_b(rst_b), .e(e), .rw(rw), .pair_select(pair_select),
		.select_high_a(select_high_a), .select_high_b(select_high_b), .select_low_c_b(select_low_c_b),
		.d_in(d_in), .d_out(d_out), .d_oe_b(d_oe_b), .irq_out(irq_out), .irq_oe_b(irq_oe_b),
		.tx_clk(tx_clk), .rx_clk(rx_clk), .rx_data_in(rx_data_in), .tx_data_out(tx_data_out),
		.cts_b(cts_b), .carrier_detect_in_b(carrier_detect_in_b), .rts_b(rts_b));
	serial_peer u_serial_peer (
		.tx_clk(tx_clk), .rx_clk(rx_clk), .rx_data_in(rx_data_in), .tx_data_out(tx_data_out),
		.cts_b(cts_b), .carrier_detect_in_b(carrier_detect_in_b));

	// System clock, 10 ns period
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Cut a hang short; the whole run needs well under this many cycles
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			bad_count++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check

	// One enable pulse, seven cycles high and seven low; drivers seen at end of high phase
	task automatic bus(input logic r, input logic ps, input logic [7:0] wd, output logic [7:0] q);
		logic drive;
		@(posedge clk_sys);
		// Selects are read after the edge so that changes made just before the call count
		drive = r & select_high_a & select_high_b & ~select_low_c_b;
		e <= 1'b1;
		rw <= r;
		pair_select <= ps;
		d_in <= wd;
		repeat (6) @(posedge clk_sys);
		#1;
		q = d_out;
		check("bus drivers enable", {7'h00, ~drive}, {7'h00, d_oe_b});
		@(posedge clk_sys);
		e <= 1'b0;
		repeat (6) @(posedge clk_sys);
		#1;
		check("bus drivers idle", 8'h01, {7'h00, d_oe_b});
		// Return on an edge so that callers change pins at the rising edge
		@(posedge clk_sys);
	endtask : bus

	function automatic logic [7:0] ctl(input logic rie, input logic [1:0] txc);
		ctl = {rie, txc, 3'h5, serial_adapter_pkg::DIV_16};
	endfunction : ctl

	// Read status until the masked bits are all set, bounded
	task automatic wait_status(input logic [7:0] mask);
		for (int i = 0; i < 400 && (rd & mask) !== mask; i++)
			bus(1'b1, 1'b0, 8'h00, rd);
	endtask : wait_status

	task automatic t_init();
		bus(1'b1, 1'b0, 8'h00, rd);
		check("status at power on", 8'h00, rd);
		bus(1'b0, 1'b0, 8'h03, rd);
		bus(1'b0, 1'b0, ctl(1'b0, 2'h0), rd);
		bus(1'b1, 1'b0, 8'h00, rd);
		check("status after setup", 8'h02, rd);
	endtask : t_init

	task automatic t_select();
		select_high_a <= 1'b0;
		bus(1'b0, 1'b0, 8'h03, rd);
		bus(1'b1, 1'b0, 8'h00, rd);
		select_high_a <= 1'b1;
		select_low_c_b <= 1'b1;
		bus(1'b1, 1'b0, 8'h00, rd);
		select_low_c_b <= 1'b0;
		bus(1'b1, 1'b0, 8'h00, rd);
		check("status after unselected write", 8'h02, rd);
	endtask : t_select

	// Every transmit-control code; ends on interrupt enabled
	task automatic t_rts();
		logic [1:0] codes[4] = '{2'h3, 2'h0, 2'h2, 2'h1};
		foreach (codes[i]) begin
			bus(1'b0, 1'b0, ctl(1'b0, codes[i]), rd);
			check("request to send", {7'h00, codes[i] == 2'h2}, {7'h00, rts_b});
		end
		check("transmit interrupt pin", 8'h00, {7'h00, irq_oe_b});
		check("interrupt pin level", 8'h00, {7'h00, irq_out});
		bus(1'b1, 1'b0, 8'h00, rd);
		check("status with transmit interrupt", 8'h82, rd);
	endtask : t_rts

	task automatic t_tx();
		repeat (3500) @(posedge clk_sys);
		u_serial_peer.got_q.delete();
		bus(1'b0, 1'b1, 8'hA5, rd);
		rd = 8'h00;
		wait_status(8'h02);
		bus(1'b0, 1'b1, 8'h5A, rd);
		bus(1'b1, 1'b0, 8'h00, rd);
		check("status with byte queued", 8'h00, rd);
		for (int i = 0; i < 9000 && u_serial_peer.got_q.size() < 2; i++)
			@(posedge clk_sys);
		check("bytes on line", 8'h02, 8'(u_serial_peer.got_q.size()));
		check("first byte", 8'hA5, u_serial_peer.got_q[0]);
		check("second byte", 8'h5A, u_serial_peer.got_q[1]);
	endtask : t_tx

	task automatic t_cts();
		cts_b <= 1'b1;
		repeat (4) @(posedge clk_sys);
		bus(1'b1, 1'b0, 8'h00, rd);
		check("status with send blocked", 8'h08, rd);
		check("interrupt masked", 8'h01, {7'h00, irq_oe_b});
		cts_b <= 1'b0;
	endtask : t_cts

	task automatic t_rx();
		bus(1'b0, 1'b0, ctl(1'b1, 2'h0), rd);
		u_serial_peer.send_byte(8'h3C);
		rd = 8'h00;
		wait_status(8'h01);
		check("status with byte held", 8'h83, rd);
		bus(1'b1, 1'b1, 8'h00, rd);
		check("received byte", 8'h3C, rd);
		bus(1'b1, 1'b0, 8'h00, rd);
		check("status after data read", 8'h02, rd);
		bus(1'b1, 1'b1, 8'h00, rd);
		check("byte kept", 8'h3C, rd);
	endtask : t_rx

	task automatic t_ovr();
		u_serial_peer.send_byte(8'h11);
		u_serial_peer.send_byte(8'h22);
		rd = 8'h00;
		wait_status(8'h20);
		check("status with overrun", 8'hA3, rd);
		bus(1'b1, 1'b1, 8'h00, rd);
		check("held byte", 8'h11, rd);
		bus(1'b1, 1'b0, 8'h00, rd);
		check("status after overrun cleared", 8'h02, rd);
	endtask : t_ovr

	task automatic t_dcd();
		carrier_detect_in_b <= 1'b1;
		repeat (10) @(posedge clk_sys);
		carrier_detect_in_b <= 1'b0;
		repeat (10) @(posedge clk_sys);
		bus(1'b1, 1'b0, 8'h00, rd);
		check("status with carrier lost", 8'h86, rd);
		bus(1'b1, 1'b1, 8'h00, rd);
		bus(1'b1, 1'b0, 8'h00, rd);
		check("status after carrier cleared", 8'h02, rd);
	endtask : t_dcd

	// Divide by one, 8 bits with even parity; the parity bit is sent wrong on purpose
	task automatic t_div1();
		bus(1'b0, 1'b0, 8'hD8, rd);
		u_serial_peer.send_frame({3'h7, 8'h3C, 1'b0}, 11, 1);
		rd = 8'h00;
		wait_status(8'h01);
		check("status with parity fault", 8'hC3, rd);
		bus(1'b1, 1'b1, 8'h00, rd);
		check("byte at divide by one", 8'h3C, rd);
		bus(1'b1, 1'b0, 8'h00, rd);
		check("parity fault kept", 8'h42, rd);
	endtask : t_div1

	// Main sequence
	initial begin
		bad_count = 0;
		comparisons = 0;
		cyc = 0;
		rst_b = 1'b0;
		e = 1'b0;
		rw = 1'b1;
		pair_select = 1'b0;
		select_high_a = 1'b1;
		select_high_b = 1'b1;
		select_low_c_b = 1'b0;
		d_in = 8'h00;
		repeat (10) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_init();
		t_select();
		t_rts();
		t_tx();
		t_cts();
		t_rx();
		t_ovr();
		t_dcd();
		t_div1();
		give_verdict();
	end
endmodule : async_serial_adapter_tb
